// *** rtl/cfg_pkg.sv ***
/*
 * Shared constants for the bus command/status and block soft-reset logic.
 * Assumes a single 50 MHz clock domain and byte-offset configuration accesses.
 */
package cfg_pkg;
   // Configuration byte offsets of the two registers held here.
   localparam logic [7:0] CMD_STATUS_OFS = 8'h04;
   localparam logic [7:0] SOFT_RESET_OFS = 8'h4c;
   // Status field positions.
   localparam int PARITY_SEEN_BIT = 31;
   localparam int SYS_ERR_BIT = 30;
   localparam int MASTER_ABORT_BIT = 29;
   localparam int TARGET_ABORT_BIT = 28;
   localparam int SIG_TABORT_BIT = 27;
   localparam int DEVSEL_LO_BIT = 25;
   localparam int MDATA_PAR_BIT = 24;
   localparam int FB2B_CAP_BIT = 23;
   localparam int UDF_BIT = 22;
   localparam int MHZ66_BIT = 21;
   // Command field positions.
   localparam int FB2B_EN_BIT = 9;
   localparam int SERR_EN_BIT = 8;
   localparam int WAIT_CTL_BIT = 7;
   localparam int PAR_RESP_BIT = 6;
   localparam int SNOOP_BIT = 5;
   localparam int MWI_BIT = 4;
   localparam int SPECIAL_BIT = 3;
   localparam int MASTER_EN_BIT = 2;
   localparam int MEM_EN_BIT = 1;
   localparam int IO_EN_BIT = 0;
   // Soft-reset field occupies bits 19:17.
   localparam int SOFT_RESET_LO = 17;
   localparam logic [15:0] CMD_WRITABLE = 16'h034f;
   localparam logic [31:0] CMD_STATUS_RESET = 32'h00800000;
   localparam logic [31:0] SOFT_RESET_RESET = 32'h00000000;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   // Bus commands driven on the byte-enable lines in multiplexed mode.
   localparam logic [3:0] CMD_MEM_READ = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [2:0] BURST_ONE = 3'h1;
   localparam logic [2:0] BURST_FOUR = 3'h4;
   typedef enum logic [2:0] {
      XFER_NONE,
      XFER_REG_READ,
      XFER_REG_WRITE,
      XFER_CFG_READ,
      XFER_CFG_WRITE
   } slave_xfer_t;
endpackage

// *** rtl/split_slave_decode.sv ***
/*
 * Slave transfer decoder for the de-multiplexed bus mode.
 * Assumes frameStart pulses in the cycle FRAME is first seen low and frameEnd
 * in the last data phase; strobe and IDSEL are valid at frameStart.
 */
module split_slave_decode
   import cfg_pkg::*;
(
   input wire logic refClk,
   input wire logic resetN,
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic wrRdIn,
   input wire logic idsel,
   output slave_xfer_t slaveXfer
);
   slave_xfer_t xfer_r;
   slave_xfer_t xfer_nxt;

   // The strobe and IDSEL pair pick one of four slave transfers.
   always_comb begin
      xfer_nxt = xfer_r;
      if (frameStart) begin
         unique case ({wrRdIn, idsel})
            2'b00: xfer_nxt = XFER_REG_READ;
            2'b10: xfer_nxt = XFER_REG_WRITE;
            2'b01: xfer_nxt = XFER_CFG_READ;
            2'b11: xfer_nxt = XFER_CFG_WRITE;
         endcase
      end else if (frameEnd) begin
         xfer_nxt = XFER_NONE;
      end
   end

   // The decode is latched at frameStart and held until frameEnd, whatever the strobe does.
   always_ff @(posedge refClk or negedge resetN) begin
      if (!resetN) begin
         xfer_r <= XFER_NONE;
      end else begin
         xfer_r <= xfer_nxt;
      end
   end

   assign slaveXfer = xfer_r;

   chk_decode_holds: assert property (@(posedge refClk) disable iff (!resetN)
      (xfer_r != XFER_NONE && !frameStart && !frameEnd) |=> $stable(xfer_r))
      else $error("Slave decode changed inside a transfer.");
endmodule

// *** rtl/cmd_status_regs.sv ***
/*
 * Command/status and block soft-reset configuration registers, error flag
 * capture, system error pin, master command handling for both the
 * multiplexed and the de-multiplexed bus modes, and slave decode in the latter.
 * Assumes the bus core reports events as one-cycle pulses on refClk and
 * presents configuration accesses already decoded to a byte offset.
 */
// Behaviour
// - master abort sets bit 29 flag
// - target abort on own master sets bit 28
// - signaled target abort bit 27 reads zero
// - DEVSEL timing reads 01, medium decode
// - bit 24 needs PERR, mastership, parity enable
// - capability bits read one, zero, zero
// - bit 9 allows back-to-back to others
// - system error driver only with bit 8
// - no stepping, bit 7 fixed zero
// - bit 6 enables parity error action
// - bits 5 and 4 fixed zero
// - bit 3 writable, special cycles ignored
// - bit 2 enables mastering, host sets first
// - bit 1 enables memory response, host first
// - I/O never accepted, bit 0 inert
// - soft-reset bit 0 holds PCM core
// - soft-reset bit 1 holds local bus blocks
// - soft-reset bit 2 holds serial controllers
// - mode input selects multiplexed or split bus
// - split mode uses strobe, not command nibble
// - only first master burst address driven
// - four-dword bursts need enable and split mode
// - with bit 8, system error flag on aborts or on address parity with bit 6
// - bit 31 set on any parity error
// - split address and strobe held whole transfer
// - split slave decode by strobe and IDSEL
module cmd_status_regs
   import cfg_pkg::*;
#(
   parameter int ADDR_W = 30
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgOffset,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   input wire logic masterAbortEvt,
   input wire logic targetAbortEvt,
   input wire logic perrEvt,
   input wire logic perrAsMaster,
   input wire logic parityErrEvt,
   input wire logic addrParityErrEvt,
   output logic systemErrorOut,
   output logic systemErrorOeN,
   output logic [1:0] devselTiming,
   output logic fastB2bOtherAgents,
   output logic parityActionEnable,
   output logic masterEnable,
   output logic memRespondEnable,
   output logic ioRespondEnable,
   output logic pcmCoreHold,
   output logic localBusHold,
   output logic serialCtrlHold,
   input wire logic split_bus_select,
   input wire logic split_burst_enable,
   output logic [2:0] burstMaxDwords,
   input wire logic mstStart,
   input wire logic mstWrite,
   input wire logic [ADDR_W-1:0] mstAddr,
   input wire logic mstDone,
   output logic [ADDR_W-1:0] mstAddrOut,
   output logic mstAddrOeN,
   output logic [3:0] mstCmdOut,
   output logic mstCmdOeN,
   output logic wrRdOut,
   output logic wrRdOeN,
   input wire logic wrRdIn,
   input wire logic idsel,
   input wire logic frameStart,
   input wire logic frameEnd,
   output slave_xfer_t slaveXfer
);
   logic [15:0] cmd_r;
   logic parSeen_r, sysErr_r, mAbort_r, tAbort_r, mDataPar_r;
   logic [2:0] softReset_r;
   logic splitMode_r;
   logic modeTaken_r;
   logic [31:0] rdData_r;
   logic rdValid_r;
   logic serrPulse_r;
   logic mstBusy_r;
   logic mstWrite_r;
   logic [ADDR_W-1:0] mstAddr_r;
   logic [31:0] statusWord;
   logic [31:0] wrMask;
   logic cmdHit, rstHit;
   logic sysErrEvt;
   logic [31:0] clrBits;

   // Byte enables widen to a bit mask; each lane writes only its own byte.
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wrMask[b*8 +: 8] = {8{cfgByteEn[b]}};
      end
   end

   assign cmdHit = cfgOffset == CMD_STATUS_OFS;
   assign rstHit = cfgOffset == SOFT_RESET_OFS;
   assign clrBits = (cfgWrite && cmdHit) ? (cfgWrData & wrMask) : 32'h00000000;

   // A system error needs the driver enabled and one of the qualifying causes.
   assign sysErrEvt = cmd_r[SERR_EN_BIT] && (masterAbortEvt || targetAbortEvt ||
      (addrParityErrEvt && cmd_r[PAR_RESP_BIT]));

   // Command bits; only the writable mask is stored, fixed bits stay zero.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_r <= CMD_STATUS_RESET[15:0];
      end else if (cfgWrite && cmdHit) begin
         // Bits 7, 5 and 4 are outside the mask, so they never leave zero.
         cmd_r <= (cmd_r & ~(wrMask[15:0] & CMD_WRITABLE)) |
            (cfgWrData[15:0] & wrMask[15:0] & CMD_WRITABLE);
      end
   end

   // Error flags are set by hardware and cleared by writing ones; a set in the
   // same cycle as the clear wins so no event is lost.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         parSeen_r <= 1'b0;
         sysErr_r <= 1'b0;
         mAbort_r <= 1'b0;
         tAbort_r <= 1'b0;
         mDataPar_r <= 1'b0;
      end else begin
         parSeen_r <= parityErrEvt || (parSeen_r && !clrBits[PARITY_SEEN_BIT]);
         sysErr_r <= sysErrEvt || (sysErr_r && !clrBits[SYS_ERR_BIT]);
         mAbort_r <= masterAbortEvt || (mAbort_r && !clrBits[MASTER_ABORT_BIT]);
         tAbort_r <= targetAbortEvt || (tAbort_r && !clrBits[TARGET_ABORT_BIT]);
         mDataPar_r <= (perrEvt && perrAsMaster && cmd_r[PAR_RESP_BIT]) ||
            (mDataPar_r && !clrBits[MDATA_PAR_BIT]);
      end
   end

   // Soft-reset field; other bits of the register read as zero.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         softReset_r <= SOFT_RESET_RESET[SOFT_RESET_LO +: 3];
      end else if (cfgWrite && rstHit) begin
         for (int i = 0; i < 3; i++) begin
            if (wrMask[SOFT_RESET_LO + i]) begin
               softReset_r[i] <= cfgWrData[SOFT_RESET_LO + i];
            end
         end
      end
   end

   // Each field bit holds its block as the external reset would.
   assign pcmCoreHold = softReset_r[0] || !reset_n;
   assign localBusHold = softReset_r[1] || !reset_n;
   assign serialCtrlHold = softReset_r[2] || !reset_n;

   // The mode pin is a strap: caught once in the first cycle after reset, so
   // a glitch on it later cannot flip the bus protocol mid-operation.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         modeTaken_r <= 1'b0;
         splitMode_r <= 1'b0;
      end else if (!modeTaken_r) begin
         modeTaken_r <= 1'b1;
         splitMode_r <= split_bus_select;
      end
   end

   // Status half: flags plus constant capability and timing fields.
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[PARITY_SEEN_BIT] = parSeen_r;
      statusWord[SYS_ERR_BIT] = sysErr_r;
      statusWord[MASTER_ABORT_BIT] = mAbort_r;
      statusWord[TARGET_ABORT_BIT] = tAbort_r;
      statusWord[SIG_TABORT_BIT] = 1'b0;
      statusWord[DEVSEL_LO_BIT +: 2] = DEVSEL_MEDIUM;
      statusWord[MDATA_PAR_BIT] = mDataPar_r;
      statusWord[FB2B_CAP_BIT] = 1'b1;
      statusWord[UDF_BIT] = 1'b0;
      statusWord[MHZ66_BIT] = 1'b0;
      statusWord[15:0] = cmd_r;
   end

   // Reads answer one cycle later; offsets not held here read as zero.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_r <= 32'h00000000;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= cfgRead;
         if (cfgRead) begin
            if (cmdHit) begin
               rdData_r <= statusWord;
            end else if (rstHit) begin
               rdData_r <= {12'h000, softReset_r, 17'h00000};
            end else begin
               rdData_r <= 32'h00000000;
            end
         end
      end
   end

   assign cfgRdData = rdData_r;
   assign cfgRdValid = rdValid_r;

   // System error pin is open drain: pulled low one cycle per event, and only
   // while the enable bit allows the driver.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         serrPulse_r <= 1'b0;
      end else begin
         serrPulse_r <= sysErrEvt;
      end
   end

   assign systemErrorOut = 1'b0;
   assign systemErrorOeN = !(serrPulse_r && cmd_r[SERR_EN_BIT]);

   // Enables presented to the bus core. Special cycles have no consumer.
   assign devselTiming = DEVSEL_MEDIUM;
   assign fastB2bOtherAgents = cmd_r[FB2B_EN_BIT];
   assign parityActionEnable = cmd_r[PAR_RESP_BIT];
   assign masterEnable = cmd_r[MASTER_EN_BIT];
   assign memRespondEnable = cmd_r[MEM_EN_BIT];
   assign ioRespondEnable = 1'b0;

   // The split burst bit counts only in split mode; elsewhere single dwords.
   assign burstMaxDwords = (split_burst_enable && splitMode_r) ? BURST_FOUR :
      BURST_ONE;

   // Master transfer: the first address is latched and held, never stepped;
   // a later burst beat reuses it and the far side must increment.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mstBusy_r <= 1'b0;
         mstWrite_r <= 1'b0;
         mstAddr_r <= '0;
      end else if (mstStart && !mstBusy_r && cmd_r[MASTER_EN_BIT]) begin
         mstBusy_r <= 1'b1;
         mstWrite_r <= mstWrite;
         mstAddr_r <= mstAddr;
      end else if (mstDone) begin
         mstBusy_r <= 1'b0;
      end
   end

   // In split mode the address stays driven for the whole transfer and the
   // strobe gives direction; otherwise the command nibble does.
   assign mstAddrOut = mstAddr_r;
   assign mstAddrOeN = !(mstBusy_r && splitMode_r);
   assign mstCmdOut = mstWrite_r ? CMD_MEM_WRITE : CMD_MEM_READ;
   assign mstCmdOeN = !(mstBusy_r && !splitMode_r);
   assign wrRdOut = mstWrite_r;
   assign wrRdOeN = !(mstBusy_r && splitMode_r);

   // Slave decode is meaningful only in split mode; frames are gated here.
   split_slave_decode slaveDecode (
      .refClk(ref_clk),
      .resetN(reset_n),
      .frameStart(frameStart && splitMode_r),
      .frameEnd(frameEnd),
      .wrRdIn(wrRdIn),
      .idsel(idsel),
      .slaveXfer(slaveXfer)
   );

   sequence s_cmd_write;
      cfgWrite && cmdHit;
   endsequence

   sequence s_read_cmd;
      cfgRead && cmdHit;
   endsequence

   chk_mabort_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
      masterAbortEvt |=> mAbort_r) else $error("Master abort flag not set.");

   chk_tabort_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
      targetAbortEvt |=> tAbort_r) else $error("Target abort flag not set.");

   chk_fixed_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_read_cmd |=> {cfgRdData[27:25], cfgRdData[23:21]} == 6'h0c && cfgRdValid)
      else $error("Fixed status bits read wrong.");

   chk_mdata_parity: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(mDataPar_r) |-> $past(perrEvt && perrAsMaster && cmd_r[PAR_RESP_BIT]))
      else $error("Master data parity flag set without cause.");

   chk_serr_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !cmd_r[SERR_EN_BIT] |=> systemErrorOeN)
      else $error("System error driven while disabled.");

   chk_fixed_cmd: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_cmd_write |=> cmd_r[7] == 1'b0 && cmd_r[5:4] == 2'h0)
      else $error("Fixed command bits became set.");

   chk_parity_seen: assert property (@(posedge ref_clk) disable iff (!reset_n)
      parityErrEvt ##1 (!parityErrEvt && !clrBits[PARITY_SEEN_BIT]) |=> parSeen_r)
      else $error("Parity flag lost before a clear.");

   chk_sys_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (masterAbortEvt && cmd_r[SERR_EN_BIT]) |=> sysErr_r ##0 !systemErrorOeN)
      else $error("System error not signaled after master abort.");

   chk_burst_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !splitMode_r |-> burstMaxDwords == BURST_ONE)
      else $error("Four-dword burst allowed outside split mode.");

   chk_first_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (mstBusy_r && !mstDone) |=> $stable(mstAddrOut))
      else $error("Master address changed inside a transfer.");

   chk_soft_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (cfgWrite && rstHit && cfgByteEn[2]) |=> pcmCoreHold == $past(cfgWrData[17]))
      else $error("Core hold does not follow its soft-reset bit.");

   // The remaining field bits must steer their own blocks, not a neighbour's.
   chk_local_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (cfgWrite && rstHit && cfgByteEn[2]) |=> localBusHold == $past(cfgWrData[18]))
      else $error("Local bus hold does not follow its soft-reset bit.");

   chk_serial_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (cfgWrite && rstHit && cfgByteEn[2]) |=> serialCtrlHold == $past(cfgWrData[19]))
      else $error("Serial hold does not follow its soft-reset bit.");

   chk_mem_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (s_cmd_write && cfgByteEn[0]) |=> memRespondEnable == $past(cfgWrData[MEM_EN_BIT]))
      else $error("Memory response enable does not follow its command bit.");

   // A start without mastering permission must leave the drivers released.
   chk_start_refused: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (mstStart && !mstBusy_r && !cmd_r[MASTER_EN_BIT]) |=> !mstBusy_r)
      else $error("Master transfer started while mastering was disabled.");
endmodule

// *** test/bus_partner.sv ***
/*
 * Far-side model: the host bridge that ends the block's master transfers and
 * drives frames at it in the split bus mode.
 * Assumes the block's drivers and frame inputs sit on the single ref_clk.
 */
module bus_partner
   import cfg_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic drvOeN,
   input wire logic [3:0] doneDelay,
   input wire logic frameGo,
   input wire logic frameWr,
   input wire logic frameSel,
   input wire logic [3:0] frameLen,
   output logic mstDone,
   output logic frameStart,
   output logic frameEnd,
   output logic wrRdHost,
   output logic idsel,
   output logic frameBusy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] doneCnt;
   logic [3:0] frameCnt;

   // Ends a master transfer after a chosen number of wait cycles.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {mstDone, doneCnt} <= '0;
      end else begin
         mstDone <= 1'b0;
         if (!drvOeN && !mstDone) begin
            mstDone <= (doneCnt == doneDelay);
            doneCnt <= (doneCnt == doneDelay) ? 4'h0 : doneCnt + 4'h1;
         end
      end
   end

   // Strobe and select stay put for the whole frame, then are inverted so a stale value shows.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {frameStart, frameEnd, wrRdHost, idsel, frameBusy, frameCnt} <= '0;
      end else begin
         {frameStart, frameEnd} <= 2'h0;
         if (frameGo && !frameBusy) begin
            {frameStart, frameBusy, wrRdHost, idsel} <= {2'h3, frameWr, frameSel};
            frameCnt <= frameLen;
         end else if (frameBusy) begin
            frameCnt <= frameCnt - 4'h1;
            frameEnd <= (frameCnt == 4'h1) && !frameEnd;
            if (frameEnd) begin
               {frameBusy, wrRdHost, idsel} <= {1'b0, ~wrRdHost, ~idsel};
            end
         end
      end
   end
endmodule

// *** test/tb_top.sv ***
/*
 * Self-checking bench for the command/status and soft-reset registers.
 * Assumes the hand-over timing: reads answer one cycle after being taken.
 */
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failCount++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top
   import cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset_n, cfgWrite, cfgRead, cfgRdValid, systemErrorOut, systemErrorOeN;
   logic [7:0] cfgOffset;
   logic [3:0] cfgByteEn, mstCmdOut, doneDelay, frameLen;
   logic [31:0] cfgWrData, cfgRdData, x;
   logic [1:0] devselTiming;
   logic [5:0] evts, evV;
   logic fastB2bOtherAgents, parityActionEnable, masterEnable, memRespondEnable;
   logic ioRespondEnable, pcmCoreHold, localBusHold, serialCtrlHold, split_bus_select;
   logic split_burst_enable, mstStart, mstWrite, mstDone, mstAddrOeN, mstCmdOeN;
   logic wrRdOut, wrRdOeN, wrRdIn, wrRdHost, idsel, frameStart, frameEnd;
   logic frameGo, frameWr, frameSel, frameBusy;
   logic [2:0] burstMaxDwords;
   logic [29:0] mstAddr, mstAddrOut, a;
   logic [15:0] cmdV;
   slave_xfer_t slaveXfer;
   slave_xfer_t xt[4] = '{XFER_REG_READ, XFER_REG_WRITE, XFER_CFG_READ, XFER_CFG_WRITE};
   int seed = 32'h9e54;
   int failCount = 0;
   int checks = 0;
   int n;

   logic masterAbortEvt, targetAbortEvt, perrEvt, perrAsMaster, parityErrEvt, addrParityErrEvt;

   // Event pulses travel as one vector; the shared wire follows whoever enables it.
   assign {masterAbortEvt, targetAbortEvt, perrEvt, perrAsMaster, parityErrEvt,
      addrParityErrEvt} = evts;
   assign wrRdIn = wrRdOeN ? wrRdHost : wrRdOut;

   cmd_status_regs cmd_status_regs_inst (.ref_clk, .reset_n, .cfgWrite, .cfgRead, .cfgOffset,
      .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .masterAbortEvt, .targetAbortEvt,
      .perrEvt, .perrAsMaster, .parityErrEvt, .addrParityErrEvt, .systemErrorOut,
      .systemErrorOeN, .devselTiming, .fastB2bOtherAgents, .parityActionEnable, .masterEnable,
      .memRespondEnable, .ioRespondEnable, .pcmCoreHold, .localBusHold, .serialCtrlHold,
      .split_bus_select, .split_burst_enable, .burstMaxDwords, .mstStart, .mstWrite, .mstAddr,
      .mstDone, .mstAddrOut, .mstAddrOeN, .mstCmdOut, .mstCmdOeN, .wrRdOut, .wrRdOeN, .wrRdIn,
      .idsel, .frameStart, .frameEnd, .slaveXfer);
   bus_partner bus_partner_inst (.ref_clk, .reset_n, .drvOeN(mstAddrOeN & mstCmdOeN),
      .doneDelay, .frameGo, .frameWr, .frameSel, .frameLen, .mstDone, .frameStart, .frameEnd,
      .wrRdHost, .idsel, .frameBusy);

   // Free-running 50 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Status word expected after one burst of events on a given command half.
   function automatic logic [31:0] expSt(input logic [15:0] c, input logic [5:0] e);
      logic [31:0] s;
      s = 32'h02800000 | {16'h0, c & 16'h034f};
      s[31] = e[1] | e[0];
      s[30] = c[8] & (e[5] | e[4] | (e[0] & c[6]));
      s[29] = e[5];
      s[28] = e[4];
      s[24] = e[3] & e[2] & c[6];
      return s;
   endfunction

   task automatic stop_test();
      $display("checks=%0d failCount=%0d", checks, failCount);
      if (failCount == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] o, input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk);
      {cfgWrite, cfgOffset, cfgByteEn, cfgWrData} <= {1'b1, o, be, d};
      @(posedge ref_clk);
      cfgWrite <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] o, input logic [31:0] e);
      @(posedge ref_clk);
      {cfgRead, cfgOffset} <= {1'b1, o};
      @(posedge ref_clk);
      cfgRead <= 1'b0;
      #1;
      `CHK({cfgRdValid, cfgRdData}, {1'b1, e})
   endtask

   // Holds reset for five cycles; the mode strap is set up before release.
   task automatic do_reset(input logic m);
      @(posedge ref_clk);
      {reset_n, split_bus_select} <= {1'b0, m};
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK({serialCtrlHold, localBusHold, pcmCoreHold, mstAddrOeN, mstCmdOeN}, 5'h1f)
      @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      {cfgWrite, cfgRead, cfgOffset, cfgByteEn, cfgWrData, evts, reset_n, split_bus_select} = '0;
      {split_burst_enable, mstStart, mstWrite, mstAddr, doneDelay} = '0;
      {frameGo, frameWr, frameSel, frameLen} = '0;
      for (int m = 0; m < 2; m++) begin
         do_reset(m[0]);
         rd(8'h04, 32'h02800000);
         rd(8'h4c, 32'h0);
         wr(8'h08, 4'hf, 32'hffffffff);
         rd(8'h08, 32'h0);
         wr(8'h04, 4'h2, 32'hffffffff);
         rd(8'h04, 32'h02800300);
         // Random command halves and event bursts, corners first.
         for (int i = 0; i < 10; i++) begin
            cmdV = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($random(seed));
            evV = (i < 2) ? 6'h3f : 6'($random(seed));
            wr(8'h04, 4'hf, {16'hffff, cmdV});
            @(posedge ref_clk);
            evts <= {evV[5:2], evV[1] | evV[0], evV[0]};
            @(posedge ref_clk);
            evts <= 6'h0;
            #1;
            x = expSt(cmdV, evV);
            `CHK(systemErrorOeN, ~x[30])
            @(posedge ref_clk);
            #1;
            `CHK({systemErrorOeN, systemErrorOut, devselTiming}, 4'h9)
            rd(8'h04, x);
            `CHK({fastB2bOtherAgents, parityActionEnable, masterEnable, memRespondEnable,
               ioRespondEnable}, {cmdV[9], cmdV[6], cmdV[2], cmdV[1], 1'b0})
         end
         wr(8'h04, 4'hf, 32'hffff0000);
         rd(8'h04, 32'h02800000);
         // Every soft-reset pattern, ending released.
         for (int k = 0; k < 9; k++) begin
            wr(8'h4c, 4'hf, {12'h0, 3'(k), 17'h0});
            #1;
            `CHK({serialCtrlHold, localBusHold, pcmCoreHold}, 3'(k))
            rd(8'h4c, {12'h0, 3'(k), 17'h0});
         end
         // A start without master permission must be ignored.
         @(posedge ref_clk);
         mstStart <= 1'b1;
         @(posedge ref_clk);
         mstStart <= 1'b0;
         #1;
         `CHK({mstAddrOeN, mstCmdOeN, wrRdOeN}, 3'h7)
         wr(8'h04, 4'hf, 32'h6);
         for (int j = 0; j < 4; j++) begin
            a = 30'($random(seed));
            @(posedge ref_clk);
            {mstStart, mstWrite, mstAddr, doneDelay, split_burst_enable} <=
               {1'b1, j[0], a, 4'(3 * j), j[1]};
            @(posedge ref_clk);
            mstStart <= 1'b0;
            #1;
            `CHK(burstMaxDwords, (m[0] & j[1]) ? 3'h4 : 3'h1)
            `CHK({mstAddrOeN, wrRdOeN, mstCmdOeN}, m[0] ? 3'h1 : 3'h6)
            if (m[0]) `CHK(wrRdOut, j[0])
            else `CHK(mstCmdOut, j[0] ? 4'h7 : 4'h6)
            for (n = 0; n < 20 && !(mstAddrOeN & mstCmdOeN); n++) begin
               if (m[0]) `CHK(mstAddrOut, a)
               @(posedge ref_clk);
               #1;
            end
            if (n == 20) begin
               failCount++;
               stop_test();
            end
         end
         // Frames of each strobe and select pairing.
         for (int j = 0; j < 4; j++) begin
            @(posedge ref_clk);
            {frameGo, frameWr, frameSel, frameLen} <= {1'b1, j[0], j[1], 4'(j + 1)};
            @(posedge ref_clk);
            frameGo <= 1'b0;
            for (n = 0; n < 20 && !(n > 0 && frameEnd); n++) begin
               @(posedge ref_clk);
               #1;
            end
            if (n == 20) begin
               failCount++;
               stop_test();
            end
            `CHK(slaveXfer, m[0] ? xt[j] : XFER_NONE)
            @(posedge ref_clk);
            #1;
            `CHK(slaveXfer, XFER_NONE)
         end
      end
      stop_test();
   end
endmodule
